// file: hdl/ahs_map.vh
`ifndef AHS_MAP_VH
`define AHS_MAP_VH
// Register port addresses
`define AHS_ADDR_CMD        3'h0
`define AHS_ADDR_DLO        3'h1
`define AHS_ADDR_DHI        3'h2
`define AHS_ADDR_STAT       3'h3
`define AHS_ADDR_AXST1      3'h4
`define AHS_ADDR_AXST2      3'h5
`define AHS_ADDR_FILT       3'h6
// Command codes
`define AHS_CMD_RANGE       16'h0100
`define AHS_CMD_ACCEL       16'h0102
`define AHS_CMD_INIT_SPD    16'h0104
`define AHS_CMD_DRIVE_SPD   16'h0105
`define AHS_CMD_PULSES      16'h0106
`define AHS_CMD_FILTER      16'h0107
`define AHS_CMD_MODE        16'h0160
`define AHS_CMD_HOME_SPD    16'h0161
`define AHS_CMD_START       16'h0162
// Status bit positions
`define AHS_ST_ERR          4
`define AHS_ST_BUSY         8
`define AHS_ST2_LIMIT       3
`define AHS_ST2_IDX_ERR     7
// Mode word fields
`define AHS_MD_PW_HI        15
`define AHS_MD_PW_LO        13
`define AHS_MD_DCC_LOW      12
`define AHS_MD_DCC_EN       11
`define AHS_MD_LIMIT_HOME   10
`define AHS_MD_IDX_AND_HOME 9
`define AHS_MD_CLR_POS      8
// Filter fields
`define AHS_FL_DLY_HI       15
`define AHS_FL_DLY_LO       13
`define AHS_FL_IDX_EN       9
`define AHS_FL_HOME_EN      8
// Speed scaling
`define AHS_RANGE_BASE      32'd8000000
`define AHS_ACC_UNIT        32'd125
// Timing at 100 MHz
`define AHS_CLK_MHZ         100
`define AHS_DCC_US_100      100
`define AHS_DCC_CYC_100     (`AHS_DCC_US_100 * `AHS_CLK_MHZ)
`define AHS_FILT_US_512     512
`define AHS_FILT_CYC_512    (`AHS_FILT_US_512 * `AHS_CLK_MHZ)
`define AHS_FILT_CYC_BASE   (`AHS_FILT_CYC_512 / 4)
`endif

// file: hdl/ahs_home_search.v
// Notes on behaviour
// - Start command code runs the home search.
// - Mode command latches low data word.
// - Mode bits 15..13 pick clear pulse width.
// - Mode bit 12 zero: clear pulse high.
// - Bit 11: clear pulse on step-3 index.
// - Bit 10 limit as home; 9 index AND home.
// - Bit 8 pulses pos_clear when the search completes, even if an alarm errors that same cycle.
// - Even bits 0-6 enable steps, odd bits 1-7 direction.
// - Filter bits 15..13 pick filter delay.
// - Filter bits 9, 8 bypass or filter inputs.
// - Busy bit high while search runs.
// - Abnormal end sets error summary and detail.
// - Step 1 fast, decelerating stop on signal.
// - Stopped inside home: escape then search.
// - Overshot home: run to limit, then recover.
// - Home active at start: skip step 1.
// - Steps 1 and 4 ramp linearly.
// - Range sets speed multiplier.
// - Accel equals parameter times 125 times multiplier.
// - Home speed command sets steps 2-3 speed.
// - Drive speed command sets steps 1 and 4 top speed.
// - Pulse count command loads 32-bit offset.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "ahs_map.vh"
module ahs_home_search (
   // Clock, reset, enable
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   // Register port
   input  wire [2:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Axis sensors, active high after input logic
   input  wire        near_home_input,
   input  wire        home_input,
   input  wire        index_input,
   input  wire        limit_pos,
   input  wire        limit_neg,
   input  wire        alarm_in,
   // Pulse generator side
   output reg         drive_pulse,
   output reg         drive_dir_neg,
   output reg         pos_clear,
   output reg         deviation_clear_pin
);

   localparam [6:0] S_IDLE = 7'h01, S_STEP1 = 7'h02, S_ESC = 7'h04, S_RECOV = 7'h08,
                    S_STEP2 = 7'h10, S_STEP3 = 7'h20, S_STEP4 = 7'h40;

   reg [15:0] data_low_ff, data_high_ff, mode_ff, filter_ff;
   reg [31:0] range_ff, accel_ff, init_spd_ff, drive_spd_ff, home_spd_ff, pulses_ff;
   reg [6:0]  state_ff;
   reg        busy_ff, err_ff, lim_err_ff, idx_err_ff, alarm_err_ff;
   reg [31:0] speed_ff, acc_ff, phase_ff, offs_cnt_ff, dcc_cnt_ff, ramp_cnt_ff;
   reg [31:0] filt_cnt_ff [0:2];
   reg [2:0]  filt_q_ff;
   reg        decel_ff, lim_seen_ff, sig_prev_ff;
   reg        dcc_armed_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Input filter: one counter per input, so home is not masked by near-home
   wire [31:0] filt_len = `AHS_FILT_CYC_BASE << filter_ff[`AHS_FL_DLY_HI:`AHS_FL_DLY_LO];
   wire [2:0]  filt_raw = {index_input, home_input, near_home_input};
   integer gi;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         filt_q_ff <= 3'h0;
         filt_cnt_ff[0] <= 32'h0;
         filt_cnt_ff[1] <= 32'h0;
         filt_cnt_ff[2] <= 32'h0;
      end else if (clk_en) begin
         for (gi = 0; gi < 3; gi = gi + 1) begin
            if (filt_raw[gi] == filt_q_ff[gi])
               filt_cnt_ff[gi] <= 32'h0;
            else if (filt_cnt_ff[gi] + 32'h1 >= filt_len) begin
               filt_q_ff[gi] <= filt_raw[gi];
               filt_cnt_ff[gi] <= 32'h0;
            end else
               filt_cnt_ff[gi] <= filt_cnt_ff[gi] + 32'h1;
         end
      end
   end
   // One enable bit switches near-home and home together
   wire use_hf = filter_ff[`AHS_FL_HOME_EN];
   wire sig_nh = use_hf ? filt_q_ff[0] : near_home_input;
   wire sig_hm_raw = use_hf ? filt_q_ff[1] : home_input;
   wire sig_ix = filter_ff[`AHS_FL_IDX_EN] ? filt_q_ff[2] : index_input;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decoding
   wire dir_neg1 = mode_ff[1];
   wire dir_neg2 = mode_ff[3];
   wire dir_neg3 = mode_ff[5];
   wire dir_neg4 = mode_ff[7];
   wire lim_home = dir_neg2 ? limit_neg : limit_pos;
   wire sig_hm = mode_ff[`AHS_MD_LIMIT_HOME] ? lim_home : sig_hm_raw;
   wire sig_s1 = mode_ff[`AHS_MD_LIMIT_HOME] ? lim_home : sig_nh;
   wire sig_s3 = mode_ff[`AHS_MD_IDX_AND_HOME] ? (sig_ix & sig_hm) : sig_ix;
   wire cur_lim = drive_dir_neg ? limit_neg : limit_pos;
   wire [31:0] mult = range_ff == 32'h0 ? 32'h1 : `AHS_RANGE_BASE / range_ff;
   wire [31:0] acc_step = accel_ff * `AHS_ACC_UNIT * mult;
   wire [31:0] init_scaled = init_spd_ff * mult;
   wire [31:0] top_scaled = drive_spd_ff * mult;
   wire [31:0] home_scaled = home_spd_ff * mult;
   // 25 us doubled per code step, so code 2 gives 100 us
   wire [31:0] dcc_len = (`AHS_DCC_CYC_100 >> 2) << mode_ff[`AHS_MD_PW_HI:`AHS_MD_PW_LO];
   wire start_cmd = reg_wr && reg_addr == `AHS_ADDR_CMD && reg_wdata == `AHS_CMD_START;
   wire [31:0] dword = {data_high_ff, data_low_ff};

   ////////////////////////////////////////////////////////////////////////////
   // Registers and parameter commands
   always @(posedge core_clk) begin
      if (!rst_n) begin
         data_low_ff <= 16'h0;
         data_high_ff <= 16'h0;
         mode_ff <= 16'h0;
         filter_ff <= 16'h0;
         range_ff <= `AHS_RANGE_BASE;
         accel_ff <= 32'h0;
         init_spd_ff <= 32'h0;
         drive_spd_ff <= 32'h0;
         home_spd_ff <= 32'h0;
         pulses_ff <= 32'h0;
         reg_rdata <= 16'h0;
      end else if (clk_en) begin
         reg_rdata <= 16'h0;
         if (reg_wr) begin
            case (reg_addr)
               `AHS_ADDR_DLO: data_low_ff <= reg_wdata;
               `AHS_ADDR_DHI: data_high_ff <= reg_wdata;
               `AHS_ADDR_CMD: begin
                  case (reg_wdata)
                     `AHS_CMD_MODE:      mode_ff <= data_low_ff;
                     `AHS_CMD_FILTER:    filter_ff <= data_low_ff;
                     `AHS_CMD_RANGE:     range_ff <= dword;
                     `AHS_CMD_ACCEL:     accel_ff <= dword;
                     `AHS_CMD_INIT_SPD:  init_spd_ff <= dword;
                     `AHS_CMD_DRIVE_SPD: drive_spd_ff <= dword;
                     `AHS_CMD_HOME_SPD:  home_spd_ff <= dword;
                     `AHS_CMD_PULSES:    pulses_ff <= dword;
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               `AHS_ADDR_STAT:  reg_rdata <= {7'h0, busy_ff, 3'h0, err_ff, 4'h0};
               `AHS_ADDR_AXST1: reg_rdata <= {alarm_err_ff, 1'b0, lim_err_ff, 13'h0};
               `AHS_ADDR_AXST2: reg_rdata <= {8'h0, idx_err_ff, 3'h0, lim_err_ff, 3'h0};
               `AHS_ADDR_FILT:  reg_rdata <= filter_ff;
               default:         reg_rdata <= 16'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Search sequencer
   task goto_after;
      input integer from;
      begin
         if (from < 2 && mode_ff[2]) begin
            state_ff <= sig_hm ? S_ESC : S_STEP2;
            drive_dir_neg <= sig_hm ? ~dir_neg2 : dir_neg2;
            speed_ff <= home_scaled;
         end else if (from < 3 && mode_ff[4]) begin
            state_ff <= S_STEP3;
            drive_dir_neg <= dir_neg3;
            speed_ff <= home_scaled;
         end else if (from < 4 && mode_ff[6]) begin
            state_ff <= S_STEP4;
            drive_dir_neg <= dir_neg4;
            speed_ff <= init_scaled;
            offs_cnt_ff <= pulses_ff;
         end else begin
            state_ff <= S_IDLE;
            busy_ff <= 1'b0;
            pos_clear <= mode_ff[`AHS_MD_CLR_POS];
         end
      end
   endtask

   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         busy_ff <= 1'b0;
         err_ff <= 1'b0;
         lim_err_ff <= 1'b0;
         idx_err_ff <= 1'b0;
         alarm_err_ff <= 1'b0;
         speed_ff <= 32'h0;
         acc_ff <= 32'h0;
         phase_ff <= 32'h0;
         offs_cnt_ff <= 32'h0;
         ramp_cnt_ff <= 32'h0;
         decel_ff <= 1'b0;
         lim_seen_ff <= 1'b0;
         sig_prev_ff <= 1'b0;
         drive_pulse <= 1'b0;
         drive_dir_neg <= 1'b0;
         pos_clear <= 1'b0;
      end else if (clk_en) begin
         drive_pulse <= 1'b0;
         pos_clear <= 1'b0;
         sig_prev_ff <= sig_s3;
         // Pulse rate: phase accumulator, one pulse per 100e6 phase units
         if (state_ff != S_IDLE) begin
            if (phase_ff + speed_ff >= 32'd100000000) begin
               phase_ff <= phase_ff + speed_ff - 32'd100000000;
               drive_pulse <= 1'b1;
            end else
               phase_ff <= phase_ff + speed_ff;
            // Ramp updates once per 1 ms; acc_step is per second
            acc_ff <= acc_step / 32'd1000;
            if (ramp_cnt_ff >= 32'd99999)
               ramp_cnt_ff <= 32'h0;
            else
               ramp_cnt_ff <= ramp_cnt_ff + 32'h1;
         end
         case (state_ff)
            S_IDLE: begin
               if (start_cmd) begin
                  busy_ff <= 1'b1;
                  err_ff <= 1'b0;
                  lim_err_ff <= 1'b0;
                  idx_err_ff <= 1'b0;
                  alarm_err_ff <= 1'b0;
                  decel_ff <= 1'b0;
                  lim_seen_ff <= 1'b0;
                  phase_ff <= 32'h0;
                  if (mode_ff[0] && !sig_hm && !sig_s1) begin
                     state_ff <= S_STEP1;
                     drive_dir_neg <= dir_neg1;
                     speed_ff <= init_scaled;
                  end else
                     goto_after(1);
               end
            end
            S_STEP1: begin
               if (sig_s1 || cur_lim)
                  decel_ff <= 1'b1;
               if (decel_ff || sig_s1 || cur_lim) begin
                  if (speed_ff <= init_scaled + acc_ff) begin
                     decel_ff <= 1'b0;
                     goto_after(1);
                  end else if (ramp_cnt_ff == 32'h0)
                     speed_ff <= speed_ff - acc_ff;
               end else if (ramp_cnt_ff == 32'h0 && speed_ff < top_scaled)
                  speed_ff <= (speed_ff + acc_ff > top_scaled) ? top_scaled : speed_ff + acc_ff;
            end
            S_ESC: begin
               if (!sig_hm) begin
                  state_ff <= S_STEP2;
                  drive_dir_neg <= dir_neg2;
               end else if (cur_lim) begin
                  lim_err_ff <= 1'b1;
                  err_ff <= 1'b1;
                  state_ff <= S_IDLE;
                  busy_ff <= 1'b0;
               end
            end
            S_STEP2: begin
               if (sig_hm)
                  goto_after(2);
               else if (cur_lim) begin
                  if (lim_seen_ff) begin
                     lim_err_ff <= 1'b1;
                     err_ff <= 1'b1;
                     state_ff <= S_IDLE;
                     busy_ff <= 1'b0;
                  end else begin
                     lim_seen_ff <= 1'b1;
                     state_ff <= S_RECOV;
                     drive_dir_neg <= ~dir_neg2;
                  end
               end
            end
            S_RECOV: begin
               // Back off through home until it clears, then search again
               if (sig_hm)
                  lim_seen_ff <= 1'b0;
               else if (!lim_seen_ff) begin
                  state_ff <= S_STEP2;
                  drive_dir_neg <= dir_neg2;
                  lim_seen_ff <= 1'b1;
               end else if (cur_lim) begin
                  lim_err_ff <= 1'b1;
                  err_ff <= 1'b1;
                  state_ff <= S_IDLE;
                  busy_ff <= 1'b0;
               end
            end
            S_STEP3: begin
               if (sig_s3 && !sig_prev_ff)
                  goto_after(3);
               else if (sig_s3 || cur_lim) begin
                  idx_err_ff <= sig_s3;
                  lim_err_ff <= cur_lim;
                  err_ff <= 1'b1;
                  state_ff <= S_IDLE;
                  busy_ff <= 1'b0;
               end
            end
            S_STEP4: begin
               if (cur_lim) begin
                  lim_err_ff <= 1'b1;
                  err_ff <= 1'b1;
                  state_ff <= S_IDLE;
                  busy_ff <= 1'b0;
               end else if (offs_cnt_ff == 32'h0)
                  goto_after(4);
               else begin
                  if (drive_pulse)
                     offs_cnt_ff <= offs_cnt_ff - 32'h1;
                  if (ramp_cnt_ff == 32'h0) begin
                     if (offs_cnt_ff < (speed_ff >> 7) && speed_ff > init_scaled + acc_ff)
                        speed_ff <= speed_ff - acc_ff;
                     else if (speed_ff + acc_ff <= top_scaled)
                        speed_ff <= speed_ff + acc_ff;
                  end
               end
            end
            default: state_ff <= S_IDLE;
         endcase
         if (alarm_in && busy_ff) begin
            alarm_err_ff <= 1'b1;
            err_ff <= 1'b1;
            state_ff <= S_IDLE;
            busy_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Deviation-counter clear pulse
   always @(posedge core_clk) begin
      if (!rst_n) begin
         dcc_cnt_ff <= 32'h0;
         dcc_armed_ff <= 1'b0;
         deviation_clear_pin <= 1'b0;
      end else if (clk_en) begin
         if (state_ff == S_STEP3 && sig_s3 && !sig_prev_ff && mode_ff[`AHS_MD_DCC_EN]) begin
            dcc_cnt_ff <= dcc_len;
            dcc_armed_ff <= 1'b1;
         end else if (dcc_cnt_ff != 32'h0)
            dcc_cnt_ff <= dcc_cnt_ff - 32'h1;
         else
            dcc_armed_ff <= 1'b0;
         deviation_clear_pin <= (dcc_armed_ff && dcc_cnt_ff != 32'h0) ^ mode_ff[`AHS_MD_DCC_LOW];
      end
   end

endmodule

// file: tb/ahs_checker_assertions.sv
module ahs_checker (
   // Clock and reset
   input wire        core_clk,
   input wire        rst_n,
   input wire        clk_en,
   // Register port
   input wire [2:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   // Axis outputs
   input wire        drive_pulse,
   input wire        pos_clear,
   input wire        deviation_clear_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] dlo_ff;
   logic [15:0] mode_ff;
   logic [1:0]  age_ff;
   logic        run_ff;
   logic [31:0] cnt_ff;
   wire         act  = deviation_clear_pin != mode_ff[12];
   wire         wcmd = clk_en && reg_wr && reg_addr == 3'h0;
   ////////////////////////////////////////////////////////////////
   // Mode word mirrored from the register port; age hides the latch delay
   always @(posedge core_clk) begin
      if (!rst_n) begin
         dlo_ff <= 16'h0;
         mode_ff <= 16'h0;
         age_ff <= 2'h0;
         run_ff <= 1'h0;
         cnt_ff <= 32'h0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == 3'h1)
            dlo_ff <= reg_wdata;
         if (wcmd && reg_wdata == 16'h0160)
            age_ff <= 2'h0;
         else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
         if (wcmd && reg_wdata == 16'h0160)
            mode_ff <= dlo_ff;
         if (wcmd && reg_wdata == 16'h0162)
            run_ff <= 1'h1;
         cnt_ff <= act ? cnt_ff + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0)
      else $error("read data not zero outside answer cycle");
   a_pulse_started: assert property (drive_pulse |-> run_ff)
      else $error("step pulse before any start command");
   a_pulse_enable: assert property (drive_pulse |-> |{mode_ff[6], mode_ff[4], mode_ff[2], mode_ff[0]})
      else $error("step pulse with every step disabled");
   a_pulse_single: assert property (drive_pulse |=> !drive_pulse)
      else $error("step pulse longer than one cycle");
   a_clear_single: assert property (pos_clear |=> !pos_clear)
      else $error("position clear longer than one cycle");
   a_clear_mode: assert property (pos_clear |-> mode_ff[8])
      else $error("position clear with mode bit 8 low");
   a_clear_quiet: assert property (pos_clear |=> !drive_pulse [*8])
      else $error("motion continues after position clear");
   a_dcc_idle: assert property (age_ff == 2'h3 && !mode_ff[11] |-> !act)
      else $error("clear pin left idle level while disabled");
   a_dcc_width: assert property (age_ff == 2'h3 && mode_ff[15:13] == 3'h2 && $past(act) && !act
      |-> cnt_ff == 32'h2710)
      else $error("clear pulse width wrong for code 2");
endmodule

bind ahs_home_search ahs_checker i_ahs_checker (.core_clk(core_clk), .rst_n(rst_n),
   .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_pulse(drive_pulse),
   .pos_clear(pos_clear), .deviation_clear_pin(deviation_clear_pin));

// file: tb/ahs_axis_model.sv
module ahs_axis_model #(
   parameter int IDX_POS = 10,
   parameter int HOME_W  = 3,
   parameter int NEAR_W  = 20,
   parameter int LIM_POS = 1000
) (
   // Clock and reset
   input  logic core_clk,
   input  logic rst_n,
   // Drive side
   input  logic drive_pulse,
   input  logic drive_dir_neg,
   input  logic pos_clear,
   // Sensors
   output logic near_home_input,
   output logic home_input,
   output logic index_input,
   output logic limit_pos,
   output logic limit_neg
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos_ff;
   // Sensors follow position only, so every run sees the same axis
   always @(posedge core_clk) begin
      if (!rst_n || pos_clear)
         pos_ff <= 0;
      else if (drive_pulse)
         pos_ff <= drive_dir_neg ? pos_ff - 1 : pos_ff + 1;
   end
   assign home_input      = pos_ff >= -HOME_W && pos_ff <= HOME_W;
   assign near_home_input = pos_ff >= -NEAR_W && pos_ff <= NEAR_W;
   assign index_input     = pos_ff == IDX_POS || pos_ff == IDX_POS + 1;
   assign limit_pos       = pos_ff >= LIM_POS;
   assign limit_neg       = pos_ff <= -LIM_POS;
endmodule

// file: tb/ahs_home_search_bench.sv
module ahs_home_search_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        clk_en = 1'h1;
   logic        alarm_in = 1'h0;
   logic        reg_wr = 1'h0;
   logic        reg_rd = 1'h0;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [15:0] rd_v;
   logic        first_dir;
   wire  [15:0] reg_rdata;
   wire         near_home_input, home_input, index_input, limit_pos, limit_neg;
   wire         drive_pulse, drive_dir_neg, pos_clear, deviation_clear_pin;
   int          bad_count = 0, check_count = 0, cyc = 0;
   int          n_pul = 0, n_neg = 0, n_clr = 0, n_dcc = 0;
   ////////////////////////////////////////////////////////////////
   ahs_home_search i_ahs_home_search (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .near_home_input(near_home_input), .home_input(home_input),
      .index_input(index_input), .limit_pos(limit_pos), .limit_neg(limit_neg),
      .alarm_in(alarm_in), .drive_pulse(drive_pulse), .drive_dir_neg(drive_dir_neg),
      .pos_clear(pos_clear), .deviation_clear_pin(deviation_clear_pin));
   ahs_axis_model i_ahs_axis_model (.core_clk(core_clk), .rst_n(rst_n),
      .drive_pulse(drive_pulse), .drive_dir_neg(drive_dir_neg), .pos_clear(pos_clear),
      .near_home_input(near_home_input), .home_input(home_input), .index_input(index_input),
      .limit_pos(limit_pos), .limit_neg(limit_neg));
   ////////////////////////////////////////////////////////////////
   always #5 core_clk = ~core_clk;
   // Outputs are counted on the falling edge, where they have settled
   always @(negedge core_clk) begin
      if (drive_pulse && n_pul == 0)
         first_dir = drive_dir_neg;
      n_pul += drive_pulse;
      n_neg += drive_pulse && drive_dir_neg;
      n_clr += pos_clear;
      n_dcc += deviation_clear_pin;
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task rd(input logic [2:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 rd_v = reg_rdata;
   endtask
   task cmd(input logic [15:0] c, input logic [15:0] lo, input logic [15:0] hi);
      wr(3'h1, lo);
      wr(3'h2, hi);
      wr(3'h0, c);
   endtask
   // Polls busy with a bound; the watchdog catches a search that never ends
   task go_idle;
      n_pul = 0;
      n_neg = 0;
      n_clr = 0;
      n_dcc = 0;
      wr(3'h0, 16'h0162);
      for (int i = 0; i < 9000; i++) begin
         rd(3'h3);
         if (rd_v[8] === 1'h0)
            break;
      end
      chk(rd_v[8], 1'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   task t_regs;
      rd(3'h3);
      chk(rd_v, 16'h0);
      rd(3'h7);
      chk(rd_v, 16'h0);
      // Equal initial and drive speeds keep the ramp out of the short runs
      cmd(16'h0100, 16'h3880, 16'h0001);
      cmd(16'h0102, 16'h0100, 16'h0000);
      cmd(16'h0104, 16'h2710, 16'h0000);
      cmd(16'h0105, 16'h2710, 16'h0000);
      cmd(16'h0161, 16'h2710, 16'h0000);
      cmd(16'h0107, 16'h4000, 16'h0000);
      rd(3'h6);
      chk(rd_v, 16'h4000);
      $display("t_regs done");
   endtask
   task t_index;
      cmd(16'h0160, 16'h4810, 16'h0000);
      go_idle;
      chk(rd_v[4], 1'h0);
      repeat (10100) @(posedge core_clk);
      chk(n_dcc, 10000);
      chk(n_neg, 0);
      chk(index_input, 1'h1);
      $display("t_index done");
   endtask
   task t_error;
      cmd(16'h0160, 16'h1010, 16'h0000);
      repeat (3) @(posedge core_clk);
      chk(deviation_clear_pin, 1'h1);
      go_idle;
      chk(rd_v[4], 1'h1);
      rd(3'h5);
      chk(rd_v[7], 1'h1);
      chk(n_pul, 0);
      $display("t_error done");
   endtask
   task t_offset;
      cmd(16'h0160, 16'h0140, 16'h0000);
      cmd(16'h0106, 16'h0014, 16'h0000);
      go_idle;
      chk(n_pul, 20);
      chk(n_neg, 0);
      chk(n_clr, 1);
      chk(rd_v[4], 1'h0);
      $display("t_offset done");
   endtask
   task t_escape;
      cmd(16'h0160, 16'h000f, 16'h0000);
      wr(3'h0, 16'h0162);
      rd(3'h3);
      chk(rd_v[8], 1'h1);
      n_pul = 0;
      n_neg = 0;
      wr(3'h0, 16'h0162);
      for (int i = 0; i < 9000; i++) begin
         rd(3'h3);
         if (rd_v[8] === 1'h0)
            break;
      end
      chk(rd_v[8], 1'h0);
      chk(first_dir, 1'h0);
      chk(n_neg != 0, 1'h1);
      chk(home_input, 1'h1);
      $display("t_escape done");
   endtask
   // Move clear of near-home, then search back with steps 1 and 2 both negative
   task t_near;
      cmd(16'h0160, 16'h0040, 16'h0000);
      cmd(16'h0106, 16'h0028, 16'h0000);
      go_idle;
      chk(n_pul, 40);
      chk(near_home_input, 1'h0);
      cmd(16'h0160, 16'h000f, 16'h0000);
      go_idle;
      chk(first_dir, 1'h1);
      chk(n_neg, 40);
      chk(home_input, 1'h1);
      $display("t_near done");
   endtask
   // Frozen clock enable holds the run; alarm then aborts it with an error
   task t_alarm;
      cmd(16'h0160, 16'h0040, 16'h0000);
      cmd(16'h0106, 16'h0100, 16'h0000);
      n_pul = 0;
      wr(3'h0, 16'h0162);
      clk_en <= 1'h0;
      repeat (300) @(posedge core_clk);
      chk(n_pul, 0);
      clk_en <= 1'h1;
      alarm_in <= 1'h1;
      @(posedge core_clk);
      alarm_in <= 1'h0;
      rd(3'h3);
      chk(rd_v[8], 1'h0);
      chk(rd_v[4], 1'h1);
      rd(3'h4);
      chk(rd_v[15], 1'h1);
      chk(n_pul, 0);
      $display("t_alarm done");
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      t_regs;
      t_index;
      t_error;
      t_offset;
      t_escape;
      t_near;
      t_alarm;
      final_report;
   end
endmodule
